// File: src/teach_status_ctrl.sv
// Purpose: actuator teach-in, safety outputs and lamp drive
// Assumes: transponder front end and nvm image on ref_clk; safety inputs are pins
// Notes: reset_n is power-up
// Notes on behaviour
// - unlearned switch learns first detected actuator
// - at most eight re-learns, then refuse
// - sole new transponder starts learning, slow flash
// - after 20 s present, fast flash
// - power cut within 120 s confirms, else discard
// - next power-up adopts actuator, allowance minus one
// - superseded actuators are never taught again
// - ready and no fault: green lamp
// - gate lamp steady while learned actuator present
// - input lamp on when both inputs high and no mismatch lock
// - one input falls: fault shown until both low
// - internal error: red lamp until power cycle
// - output high only with actuator and input high
// - after mismatch, both low before re-enabling
`timescale 1ns/1ps
module teach_status_ctrl
  import teach_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned LEARN_HOLD_P = LEARN_HOLD_MS,
  parameter int unsigned CONFIRM_P = CONFIRM_MS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // transponder front end
  input wire logic act_present,
  input wire logic act_sole,
  input wire logic [ID_W-1:0] act_id,
  input wire logic internal_error,
  // safety inputs and outputs
  input wire logic safety_input_ch1,
  input wire logic safety_input_ch2,
  output logic safety_out_ch1,
  output logic safety_out_ch2,
  output logic signal_diag_output,
  // lamps
  output logic led_power_green,
  output logic led_power_red,
  output logic led_gate,
  output logic led_input,
  // non-volatile image read at power-up
  input wire logic nvm_learned_valid_i,
  input wire logic [ID_W-1:0] nvm_learned_id_i,
  input wire logic [3:0] nvm_allowance_i,
  input wire logic nvm_pending_i,
  input wire logic [ID_W-1:0] nvm_pending_id_i,
  input wire logic [RETIRE_SLOTS-1:0][ID_W-1:0] nvm_retired_i,
  // non-volatile image to store
  output logic nvm_wr,
  output logic nvm_learned_valid_o,
  output logic [ID_W-1:0] nvm_learned_id_o,
  output logic [3:0] nvm_allowance_o,
  output logic nvm_pending_o,
  output logic [ID_W-1:0] nvm_pending_id_o,
  output logic [RETIRE_SLOTS-1:0][ID_W-1:0] nvm_retired_o
);
  teach_state_t state_r;
  logic ms_tick;
  logic [16:0] ms_cnt_r;
  logic [7:0] flash_cnt_r;
  logic flash_r;
  logic s1_m_r, s1_r, s2_m_r, s2_r, s1_d_r, s2_d_r;
  logic lock_r;
  logic fault_r;
  logic [RETIRE_SLOTS-1:0] retired_used_r;
  logic in_range;
  logic new_ok;
  logic hold_done;
  logic confirm_done;

  function automatic logic id_retired(input logic [ID_W-1:0] id,
                                      input logic [RETIRE_SLOTS-1:0][ID_W-1:0] lst,
                                      input logic [RETIRE_SLOTS-1:0] used);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < RETIRE_SLOTS; i++) begin
      if (used[i] && lst[i] == id) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES_P)) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(ms_tick)
  );

  assign in_range = act_present && nvm_learned_valid_o && act_id == nvm_learned_id_o;
  assign new_ok = act_present && act_sole && nvm_learned_valid_o &&
                  act_id != nvm_learned_id_o && nvm_allowance_o != 4'h0 &&
                  !id_retired(act_id, nvm_retired_o, retired_used_r);
  assign hold_done = ms_tick && 32'(ms_cnt_r) >= LEARN_HOLD_P - 1;
  assign confirm_done = ms_tick && 32'(ms_cnt_r) >= CONFIRM_P - 1;

  // safety input synchronisers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {s1_m_r, s1_r, s2_m_r, s2_r, s1_d_r, s2_d_r} <= 6'h00;
    end else begin
      s1_m_r <= safety_input_ch1;
      s1_r <= s1_m_r;
      s2_m_r <= safety_input_ch2;
      s2_r <= s2_m_r;
      s1_d_r <= s1_r;
      s2_d_r <= s2_r;
    end
  end

  // partial-operation lock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_r <= 1'b0;
    end else if ((s1_d_r && !s1_r && s2_r) || (s2_d_r && !s2_r && s1_r)) begin
      lock_r <= 1'b1;
    end else if (!s1_r && !s2_r) begin
      lock_r <= 1'b0;
    end
  end

  // sticky internal fault
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= 1'b0;
    end else if (internal_error) begin
      fault_r <= 1'b1;
    end
  end

  // flash counter, stepped on the millisecond tick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_r <= 8'h00;
      flash_r <= 1'b0;
    end else if (ms_tick) begin
      if (32'(flash_cnt_r) >= ((state_r == ST_LEARN_FAST) ?
          FLASH_FAST_HALF_MS : FLASH_SLOW_HALF_MS) - 1) begin
        flash_cnt_r <= 8'h00;
        flash_r <= !flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 8'h01;
      end
    end
  end

  // teach-in sequence and persistent image
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_LOAD;
      ms_cnt_r <= MS_CNT_RESET;
      nvm_wr <= 1'b0;
      nvm_learned_valid_o <= 1'b0;
      nvm_learned_id_o <= ID_RESET;
      nvm_allowance_o <= 4'h0;
      nvm_pending_o <= 1'b0;
      nvm_pending_id_o <= ID_RESET;
      nvm_retired_o <= '0;
      retired_used_r <= '0;
    end else begin
      nvm_wr <= 1'b0;
      if (ms_tick) begin
        ms_cnt_r <= ms_cnt_r + 17'h0_0001;
      end
      case (state_r)
        ST_LOAD: begin
          nvm_learned_valid_o <= nvm_learned_valid_i;
          nvm_learned_id_o <= nvm_learned_id_i;
          nvm_allowance_o <= (nvm_allowance_i > ALLOWANCE_MAX) ? ALLOWANCE_MAX
                                                              : nvm_allowance_i;
          nvm_pending_o <= 1'b0;
          nvm_pending_id_o <= nvm_pending_id_i;
          nvm_retired_o <= nvm_retired_i;
          for (int i = 0; i < RETIRE_SLOTS; i++) begin
            retired_used_r[i] <= 4'(i) < ALLOWANCE_MAX - nvm_allowance_i;
          end
          if (nvm_pending_i && nvm_learned_valid_i && nvm_allowance_i != 4'h0 &&
              nvm_allowance_i <= ALLOWANCE_MAX) begin
            nvm_learned_id_o <= nvm_pending_id_i;
            nvm_allowance_o <= nvm_allowance_i - 4'h1;
            nvm_retired_o[3'(ALLOWANCE_MAX - nvm_allowance_i)] <= nvm_learned_id_i;
            retired_used_r[3'(ALLOWANCE_MAX - nvm_allowance_i)] <= 1'b1;
          end
          nvm_wr <= nvm_pending_i;
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          ms_cnt_r <= MS_CNT_RESET;
          if (fault_r) begin
            state_r <= ST_FAULT;
          end else if (!nvm_learned_valid_o && act_present) begin
            nvm_learned_valid_o <= 1'b1;
            nvm_learned_id_o <= act_id;
            nvm_allowance_o <= ALLOWANCE_MAX;
            nvm_wr <= 1'b1;
          end else if (new_ok) begin
            nvm_pending_id_o <= act_id;
            state_r <= ST_LEARN_SLOW;
          end
        end
        ST_LEARN_SLOW: begin
          if (fault_r || !act_present || !act_sole || act_id != nvm_pending_id_o) begin
            state_r <= ST_RUN;
          end else if (hold_done) begin
            ms_cnt_r <= MS_CNT_RESET;
            nvm_pending_o <= 1'b1;
            nvm_wr <= 1'b1;
            state_r <= ST_LEARN_FAST;
          end
        end
        ST_LEARN_FAST: begin
          if (fault_r || confirm_done || !act_present || act_id != nvm_pending_id_o) begin
            nvm_pending_o <= 1'b0;
            nvm_wr <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_FAULT: begin
          state_r <= ST_FAULT;
        end
        default: begin
          state_r <= ST_FAULT;
        end
      endcase
    end
  end

  // outputs and lamps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      safety_out_ch1 <= 1'b0;
      safety_out_ch2 <= 1'b0;
      signal_diag_output <= 1'b0;
      led_power_green <= 1'b0;
      led_power_red <= 1'b0;
      led_gate <= 1'b0;
      led_input <= 1'b0;
    end else begin
      safety_out_ch1 <= !fault_r && state_r == ST_RUN && in_range && s1_r && !lock_r;
      safety_out_ch2 <= !fault_r && state_r == ST_RUN && in_range && s2_r && !lock_r;
      signal_diag_output <= in_range && !fault_r;
      led_power_green <= !fault_r && state_r != ST_LOAD;
      led_power_red <= fault_r;
      if (state_r == ST_LEARN_SLOW || state_r == ST_LEARN_FAST) begin
        led_gate <= flash_r;
      end else begin
        led_gate <= in_range;
      end
      led_input <= lock_r ? flash_r : (s1_r && s2_r);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_OUT_SAFE: assert property (safety_out_ch1 |-> $past(in_range && s1_r && !lock_r))
    else $error("channel 1 high without cause");
  AST_OUT_SAFE2: assert property (safety_out_ch2 |-> $past(in_range && s2_r && !lock_r))
    else $error("channel 2 high without cause");
  AST_LOCK_HOLD: assert property (lock_r && (s1_r || s2_r) |=> lock_r)
    else $error("mismatch lock cleared early");
  AST_LOCK_SET: assert property (s1_d_r && !s1_r && s2_r |=> lock_r)
    else $error("mismatch not latched");
  AST_INPUT_LED: assert property (!lock_r && s1_r && s2_r |=> led_input)
    else $error("input lamp off with both inputs high");
  AST_FAULT_RED: assert property (internal_error |=> ##1 (led_power_red && !led_power_green) [*3])
    else $error("fault lamp not held red");
  AST_GREEN: assert property (state_r == ST_RUN && !fault_r |=> led_power_green)
    else $error("green lamp missing");
  AST_GATE: assert property (state_r == ST_RUN && !fault_r |=> led_gate == $past(in_range))
    else $error("gate lamp wrong");
  AST_FIRST: assert property (state_r == ST_RUN && !fault_r && !nvm_learned_valid_o &&
    act_present |=> nvm_learned_valid_o && nvm_learned_id_o == $past(act_id) && nvm_wr)
    else $error("first actuator not learned");
  AST_EXHAUST: assert property (state_r == ST_RUN && nvm_allowance_o == 4'h0
    |=> state_r != ST_LEARN_SLOW)
    else $error("learning with no allowance");
  AST_RETIRED: assert property (state_r == ST_RUN &&
    id_retired(act_id, nvm_retired_o, retired_used_r) |=> state_r != ST_LEARN_SLOW)
    else $error("superseded actuator accepted");
  AST_START: assert property (state_r == ST_RUN && !fault_r && nvm_learned_valid_o && new_ok
    |=> state_r == ST_LEARN_SLOW)
    else $error("learning not started");
  AST_FAST: assert property (state_r == ST_LEARN_SLOW && !fault_r && act_present && act_sole &&
    act_id == nvm_pending_id_o && hold_done |=> state_r == ST_LEARN_FAST && nvm_pending_o)
    else $error("fast phase not entered");
  AST_EXPIRE: assert property (state_r == ST_LEARN_FAST && confirm_done
    |=> state_r == ST_RUN && !nvm_pending_o && nvm_wr)
    else $error("pending learning not discarded");
  AST_COMMIT: assert property (state_r == ST_LOAD && nvm_pending_i && nvm_learned_valid_i &&
    nvm_allowance_i != 4'h0 && nvm_allowance_i <= ALLOWANCE_MAX
    |=> nvm_allowance_o == $past(nvm_allowance_i) - 4'h1 &&
        nvm_learned_id_o == $past(nvm_pending_id_i))
    else $error("confirmed learning not committed");
  AST_ALLOW_MAX: assert property (state_r != ST_LOAD |-> nvm_allowance_o <= ALLOWANCE_MAX)
    else $error("allowance out of range");

  COV_LEARN: cover property (state_r == ST_LEARN_SLOW ##1 state_r == ST_LEARN_FAST);
  COV_LOCK: cover property ($rose(lock_r) ##[1:20] $fell(lock_r));
  COV_OUTS: cover property (safety_out_ch1 && safety_out_ch2);
  COV_FAULT: cover property ($rose(led_power_red));
endmodule

// File: common/teach_pkg.sv
// Purpose: shared constants for the actuator teach-in and status logic
// Assumes: 200 MHz ref_clk, 1 ms tick from a divider
// Notes: long counts are in milliseconds and top-level parameters
package teach_pkg;
  localparam int ID_W = 32;
  localparam int RETIRE_SLOTS = 8;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int LEARN_HOLD_S = 20;
  localparam int LEARN_HOLD_MS = LEARN_HOLD_S * 1000;
  localparam int CONFIRM_S = 120;
  localparam int CONFIRM_MS = CONFIRM_S * 1000;
  localparam int FLASH_SLOW_HALF_MS = 250;
  localparam int FLASH_FAST_HALF_MS = 100;
  localparam logic [3:0] ALLOWANCE_MAX = 4'h8;
  localparam logic [ID_W-1:0] ID_RESET = 32'h0000_0000;
  localparam logic [16:0] MS_CNT_RESET = 17'h0_0000;
  typedef enum logic [2:0] {
    ST_LOAD, ST_RUN, ST_LEARN_SLOW, ST_LEARN_FAST, ST_FAULT
  } teach_state_t;
endpackage

// File: src/ms_tick_gen.sv
// Purpose: one-cycle enable every TICK_CYCLES clocks
// Assumes: single clock domain
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int unsigned TICK_CYCLES = 200000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // tick
  output logic tick
);
  logic [31:0] div_r;

  // divide down
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (div_r >= TICK_CYCLES - 1) begin
      div_r <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      div_r <= div_r + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

// File: verification/eval_model.sv
// Purpose: dual-channel evaluator watching both safety outputs
// Assumes: outputs sampled on ref_clk
// Notes: lasting channel disagreement latches a fault until both low
`timescale 1ns/1ps
module eval_model #(
  parameter int unsigned MISMATCH_LIM = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // monitored channels
  input wire logic chan_a,
  input wire logic chan_b,
  // verdict
  output logic release_ok,
  output logic fault
);
  logic [7:0] mis_cnt_r;

  // channels compared directly, disagreement cycles counted
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mis_cnt_r <= 8'h00;
      fault <= 1'b0;
    end else if (chan_a != chan_b) begin
      mis_cnt_r <= mis_cnt_r + 8'h01;
      if (mis_cnt_r >= MISMATCH_LIM[7:0]) begin
        fault <= 1'b1;
      end
    end else begin
      mis_cnt_r <= 8'h00;
      if (!chan_a && !chan_b) begin
        fault <= 1'b0;
      end
    end
  end

  assign release_ok = chan_a && chan_b && !fault;
endmodule

// File: verification/tb_top.sv
// Purpose: self-checking bench for teach-in, outputs and lamps
// Assumes: shortened tick and learning counts
// Notes: bench keeps the persistent image written on nvm_wr
`timescale 1ns/1ps
module tb_top;
  import teach_pkg::*;
  localparam logic [ID_W-1:0] ID_A = 32'h0000_00A1;
  localparam logic [ID_W-1:0] ID_B = 32'h0000_00B2;
  localparam logic [ID_W-1:0] ID_C = 32'h0000_00C3;
  localparam logic [ID_W-1:0] ID_D = 32'h0000_00D4;
  logic ref_clk, reset_n, act_present, act_sole, internal_error;
  logic [ID_W-1:0] act_id;
  logic safety_input_ch1, safety_input_ch2, safety_out_ch1, safety_out_ch2;
  logic signal_diag_output, led_power_green, led_power_red, led_gate, led_input;
  logic st_valid = 1'b0;
  logic st_pend = 1'b0;
  logic nvm_wr, nvm_learned_valid_o, nvm_pending_o;
  logic [ID_W-1:0] st_id = '0;
  logic [ID_W-1:0] st_pid = '0;
  logic [ID_W-1:0] nvm_learned_id_o, nvm_pending_id_o;
  logic [3:0] st_allow = ALLOWANCE_MAX;
  logic [3:0] nvm_allowance_o;
  logic [RETIRE_SLOTS-1:0][ID_W-1:0] st_ret = '0;
  logic [RETIRE_SLOTS-1:0][ID_W-1:0] nvm_retired_o;
  logic release_ok, eval_fault;
  logic drain_allow;
  int error_cnt = 0;
  int check_count = 0;

  teach_status_ctrl #(.TICK_CYCLES_P(4), .LEARN_HOLD_P(10), .CONFIRM_P(20)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .act_present(act_present),
    .act_sole(act_sole), .act_id(act_id), .internal_error(internal_error),
    .safety_input_ch1(safety_input_ch1), .safety_input_ch2(safety_input_ch2),
    .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2),
    .signal_diag_output(signal_diag_output), .led_power_green(led_power_green),
    .led_power_red(led_power_red), .led_gate(led_gate), .led_input(led_input),
    .nvm_learned_valid_i(st_valid), .nvm_learned_id_i(st_id), .nvm_allowance_i(st_allow),
    .nvm_pending_i(st_pend), .nvm_pending_id_i(st_pid), .nvm_retired_i(st_ret),
    .nvm_wr(nvm_wr), .nvm_learned_valid_o(nvm_learned_valid_o),
    .nvm_learned_id_o(nvm_learned_id_o), .nvm_allowance_o(nvm_allowance_o),
    .nvm_pending_o(nvm_pending_o), .nvm_pending_id_o(nvm_pending_id_o),
    .nvm_retired_o(nvm_retired_o));

  eval_model #(.MISMATCH_LIM(8)) evaluator (
    .ref_clk(ref_clk), .reset_n(reset_n), .chan_a(safety_out_ch1),
    .chan_b(safety_out_ch2), .release_ok(release_ok), .fault(eval_fault));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // persistent store survives power cycles
  always @(posedge ref_clk) begin
    if (nvm_wr === 1'b1) begin
      st_valid <= nvm_learned_valid_o;
      st_id <= nvm_learned_id_o;
      st_allow <= nvm_allowance_o;
      st_pend <= nvm_pending_o;
      st_pid <= nvm_pending_id_o;
      st_ret <= nvm_retired_o;
    end else if (drain_allow) begin
      st_allow <= 4'h0;
    end
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pwr();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    cyc(20);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(4);
  endtask

  task automatic set_in(input logic a, input logic b);
    @(posedge ref_clk);
    safety_input_ch1 <= a;
    safety_input_ch2 <= b;
    cyc(6);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(5000);
    error_cnt++;
    summarize();
  end

  initial begin
    reset_n = 1'b0; act_present = 1'b0; act_sole = 1'b1; act_id = ID_A;
    internal_error = 1'b0; safety_input_ch1 = 1'b0; safety_input_ch2 = 1'b0;
    drain_allow = 1'b0;
    cyc(20);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(4);
    @(posedge ref_clk);
    act_present <= 1'b1;
    cyc(6);
    chk("learned valid", 64'(nvm_learned_valid_o), 64'h1);
    chk("learned id", 64'(nvm_learned_id_o), 64'(ID_A));
    chk("green", 64'(led_power_green), 64'h1);
    chk("gate lamp", 64'(led_gate), 64'h1);
    $display("test first_learn done");
    set_in(1'b1, 1'b1);
    chk("out pair", 64'({safety_out_ch1, safety_out_ch2}), 64'h3);
    chk("input lamp", 64'(led_input), 64'h1);
    chk("evaluator release", 64'(release_ok), 64'h1);
    @(posedge ref_clk);
    act_present <= 1'b0;
    cyc(6);
    chk("out pair absent", 64'({safety_out_ch1, safety_out_ch2}), 64'h0);
    chk("gate lamp absent", 64'(led_gate), 64'h0);
    chk("diag absent", 64'(signal_diag_output), 64'h0);
    @(posedge ref_clk);
    act_present <= 1'b1;
    set_in(1'b0, 1'b1);
    chk("out1 after fall", 64'(safety_out_ch1), 64'h0);
    set_in(1'b1, 1'b1);
    chk("out pair locked", 64'({safety_out_ch1, safety_out_ch2}), 64'h0);
    set_in(1'b0, 1'b0);
    chk("input lamp cleared", 64'(led_input), 64'h0);
    set_in(1'b1, 1'b1);
    chk("out pair resumed", 64'({safety_out_ch1, safety_out_ch2}), 64'h3);
    chk("evaluator fault", 64'(eval_fault), 64'h0);
    $display("test inputs done");
    @(posedge ref_clk);
    act_id <= ID_B;
    cyc(60);
    chk("pending set", 64'(nvm_pending_o), 64'h1);
    chk("pending id", 64'(nvm_pending_id_o), 64'(ID_B));
    pwr();
    chk("adopted id", 64'(nvm_learned_id_o), 64'(ID_B));
    chk("allowance", 64'(nvm_allowance_o), 64'h7);
    chk("retired slot", 64'(nvm_retired_o[0]), 64'(ID_A));
    $display("test teach done");
    @(posedge ref_clk);
    act_sole <= 1'b0;
    act_id <= ID_C;
    cyc(60);
    chk("second tag refused", 64'(nvm_pending_o), 64'h0);
    @(posedge ref_clk);
    act_sole <= 1'b1;
    cyc(60);
    chk("pending c", 64'(nvm_pending_o), 64'h1);
    cyc(85);
    chk("pending expired", 64'(nvm_pending_o), 64'h0);
    @(posedge ref_clk);
    act_present <= 1'b0;
    cyc(5);
    @(posedge ref_clk);
    act_id <= ID_A;
    act_present <= 1'b1;
    cyc(60);
    chk("retired refused", 64'(nvm_pending_o), 64'h0);
    $display("test window done");
    @(posedge ref_clk);
    act_present <= 1'b0;
    drain_allow <= 1'b1;
    @(posedge ref_clk);
    drain_allow <= 1'b0;
    pwr();
    @(posedge ref_clk);
    act_id <= ID_D;
    act_present <= 1'b1;
    cyc(60);
    chk("allowance spent", 64'(nvm_pending_o), 64'h0);
    @(posedge ref_clk);
    internal_error <= 1'b1;
    @(posedge ref_clk);
    internal_error <= 1'b0;
    cyc(5);
    chk("red lamp", {led_power_red, led_power_green}, 64'h2);
    $display("test fault done");
    summarize();
  end
endmodule
